// [hdl/cir_top.sv]
// Interrupt routing for two interrupt pins, with an AHB-Lite register slave
//
// Operation
// R1: Enable bit 7 routes headset insertion onto the second interrupt output.
// R2: Enable bit 6 routes headset button presses onto the second output.
// R3: Enable bit 5 routes playback compressor power events onto the second output.
// R4: Enable bit 4 routes record gain noise events onto the second output.
// R5: Enable bit 3 routes driver short circuits onto the second output.
// R6: Enable bit 2 routes processing engine interrupts onto the second output.
// R7: Enable bit 1 routes the DC measurement ready event onto the second output.
// R8: Enable bit 0 low gives one 2 ms high pulse per event.
// R9: Bit 0 high repeats 2 ms pulses every 4 ms until flags read; the code also waits for a read of the shared word.
// R10: Shared bit 7 gates out-of-threshold events onto the first output.
// R11: Shared bit 6 gates pen touch and data-available onto the first output.
// R12: Shared bit 5 gates out-of-threshold events onto the second output.
// R13: Shared bit 3 reads one while a pen touch is detected.
// R14: Shared bit 2 reads one while converter data is available.
// R15: Shared bit 1 reads one while a result is out of range.
// R16: Software keeps reserved shared bit 0 at zero.
// R17: Event flags are sticky, read-only, cleared by reading them.
// R18: Any newly occurring enabled event starts a pulse sequence; the code starts one only from idle and folds later events in.
`include "cir_irq_map.svh"

module cir_top
  import cir_pkg::*;
#(
  parameter int PULSE_CYC = `CIR_PULSE_MS * `CIR_CLK_KHZ,
  parameter int PERIOD_CYC = `CIR_PERIOD_MS * `CIR_CLK_KHZ
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event sources and live status
  input wire cir_src_t src_evt,
  input wire cir_touch_t touch_st,
  // Interrupt pins and bus interrupt
  output logic first_interrupt_output,
  output logic second_interrupt_output,
  output logic irq
);

  // ==========================================================
  // Bus decode
  localparam int CW = 24;
  localparam logic [CW-1:0] HIGH_LAST = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] LOW_LAST = CW'(PERIOD_CYC - PULSE_CYC - 1);

  logic [7:0] en2_q;
  logic [7:0] shared_q;
  logic [8:0] flags_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic wr_q;
  logic [7:0] wr_idx_q;
  logic [31:0] rdata_q;
  logic rd_flags_q;
  logic rd_shared_q;
  cir_pulse_st_t st_q [2];
  logic [CW-1:0] cnt_q [2];
  logic [1:0] pin_q;
  logic [1:0] trig;
  logic [1:0] rep;
  logic [1:0] start;
  logic ack;
  logic addr_ok;
  logic rd_req;
  logic [7:0] req_idx;
  logic [7:0] shared_rd;

  // Word index from a byte address
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    return a[9:2];
  endfunction : word_idx

  // Valid transfer in the address phase
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_req = addr_ok & ~hwrite;
  assign req_idx = word_idx(haddr);

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_q <= addr_ok & hwrite;
      wr_idx_q <= req_idx;
    end
  end

  // Live status is merged into the shared register on reads
  always_comb begin
    shared_rd = shared_q & `CIR_SHR_RW_MASK;
    shared_rd[`CIR_SHR_PEN_DOWN] = touch_st.pen_down; // R13
    shared_rd[`CIR_SHR_DATA_AVAIL] = touch_st.data_avail; // R14
    shared_rd[`CIR_SHR_OUT_RANGE] = touch_st.out_range; // R15
  end

  // Read data is sampled in the address phase so it sits in a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_req) begin
      unique case (req_idx)
        `CIR_IDX_EN2: rdata_q <= {24'h00_0000, en2_q};
        `CIR_IDX_SHARED: rdata_q <= {24'h00_0000, shared_rd};
        `CIR_IDX_FLAGS: rdata_q <= {23'h00_0000, flags_q};
        `CIR_IDX_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
        `CIR_IDX_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en2_q <= `CIR_RST_EN2;
      shared_q <= `CIR_RST_SHARED;
      irq_mask_q <= `CIR_RST_IRQ_MASK;
    end else if (wr_q) begin
      if (wr_idx_q == `CIR_IDX_EN2) begin
        en2_q <= hwdata[7:0];
      end
      // Reserved bits are dropped so a stray write cannot stick
      if (wr_idx_q == `CIR_IDX_SHARED) begin
        shared_q <= hwdata[7:0] & `CIR_SHR_RW_MASK; // R16
      end
      if (wr_idx_q == `CIR_IDX_IRQ_MASK) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Sticky event flags, cleared by reading; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 9'h000;
    end else begin
      flags_q <= ((rd_req && req_idx == `CIR_IDX_FLAGS) ? 9'h000 : flags_q)
                 | src_evt; // R17
    end
  end

  // ==========================================================
  // Source routing: enabled events are ORed per output
  always_comb begin
    trig[0] = (shared_q[`CIR_SHR_OOT_FIRST] & src_evt.out_thresh) // R10
            | (shared_q[`CIR_SHR_PEN_FIRST] & src_evt.pen_dav); // R11
    trig[1] = (en2_q[`CIR_EN2_INSERT] & src_evt.hs_insert) // R1
            | (en2_q[`CIR_EN2_BUTTON] & src_evt.button) // R2
            | (en2_q[`CIR_EN2_COMPRESS] & src_evt.compress) // R3
            | (en2_q[`CIR_EN2_GAIN_NOISE] & src_evt.gain_noise) // R4
            | (en2_q[`CIR_EN2_SHORT] & src_evt.short_circ) // R5
            | (en2_q[`CIR_EN2_ENGINE] & src_evt.engine) // R6
            | (en2_q[`CIR_EN2_DC_READY] & src_evt.dc_ready) // R7
            | (shared_q[`CIR_SHR_OOT_SECOND] & src_evt.out_thresh); // R12
  end

  // The first output has no repeat control here, so it is single shot
  assign rep[0] = 1'b0;
  assign rep[1] = en2_q[`CIR_EN2_REPEAT];

  // A sequence starts only from idle; events during one are folded in
  assign start[0] = (st_q[0] == CIR_IDLE) & trig[0]; // R18
  assign start[1] = (st_q[1] == CIR_IDLE) & trig[1]; // R18

  // ==========================================================
  // Acknowledge tracking: both the flag word and the shared word read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_flags_q <= 1'b0;
      rd_shared_q <= 1'b0;
    end else begin
      // A read in the start cycle still counts
      if (rd_req && req_idx == `CIR_IDX_FLAGS) begin
        rd_flags_q <= 1'b1;
      end else if (start[1]) begin
        rd_flags_q <= 1'b0;
      end
      if (rd_req && req_idx == `CIR_IDX_SHARED) begin
        rd_shared_q <= 1'b1;
      end else if (start[1]) begin
        rd_shared_q <= 1'b0;
      end
    end
  end

  assign ack = rd_flags_q & rd_shared_q;

  // ==========================================================
  // Pulse sequencers, one per output pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        st_q[i] <= CIR_IDLE;
        cnt_q[i] <= '0;
        pin_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        unique case (st_q[i])
          CIR_IDLE: begin
            if (start[i]) begin
              st_q[i] <= CIR_HIGH;
              cnt_q[i] <= '0;
              pin_q[i] <= 1'b1;
            end
          end
          CIR_HIGH: begin
            if (cnt_q[i] == HIGH_LAST) begin
              cnt_q[i] <= '0;
              pin_q[i] <= 1'b0;
              if (rep[i] && !ack) begin
                st_q[i] <= CIR_LOW; // R9
              end else begin
                st_q[i] <= CIR_IDLE; // R8
              end
            end else begin
              cnt_q[i] <= cnt_q[i] + 1'b1;
            end
          end
          CIR_LOW: begin
            // Reading both the flag word and the shared word ends the train at once
            if (ack || !rep[i]) begin
              st_q[i] <= CIR_IDLE;
              cnt_q[i] <= '0;
            end else if (cnt_q[i] == LOW_LAST) begin
              st_q[i] <= CIR_HIGH;
              cnt_q[i] <= '0;
              pin_q[i] <= 1'b1; // R9
            end else begin
              cnt_q[i] <= cnt_q[i] + 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign first_interrupt_output = pin_q[0];
  assign second_interrupt_output = pin_q[1];

  // ==========================================================
  // Bus interrupt: a start per output, write one to clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr_q && wr_idx_q == `CIR_IDX_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~hwdata[1:0]) | start;
      end else begin
        irq_stat_q <= irq_stat_q | start;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [CW-1:0] hi_len_q;

  // Length of the current high phase, read only by a check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_len_q <= '0;
    end else begin
      hi_len_q <= second_interrupt_output ? hi_len_q + 1'b1 : '0;
    end
  end

  // The count lags the pin by one edge, so it is judged while the pin is high
  pulse_len_cap_a: assert property ( // R8
    second_interrupt_output |-> hi_len_q <= HIGH_LAST
  ) else $error("second output pulse longer than 2 ms");

  pulse_len_full_a: assert property ( // R8
    $fell(second_interrupt_output) |-> $past(hi_len_q) == HIGH_LAST
  ) else $error("second output pulse shorter than 2 ms");

  single_shot_a: assert property ( // R8
    st_q[1] == CIR_HIGH && cnt_q[1] == HIGH_LAST && !rep[1]
    |=> st_q[1] == CIR_IDLE
  ) else $error("single mode did not return to idle");

  train_stop_a: assert property ( // R9
    st_q[1] == CIR_LOW && ack |=> st_q[1] == CIR_IDLE && !second_interrupt_output
  ) else $error("pulse train not stopped after flag reads");

  train_repeat_a: assert property ( // R9
    st_q[1] == CIR_LOW && cnt_q[1] == LOW_LAST && rep[1] && !ack
    |=> second_interrupt_output
  ) else $error("pulse train did not repeat");

  oot_first_a: assert property ( // R10
    st_q[0] == CIR_IDLE && src_evt.out_thresh && shared_q[`CIR_SHR_OOT_FIRST]
    |=> first_interrupt_output
  ) else $error("threshold event missed on first output");

  pen_first_a: assert property ( // R11
    st_q[0] == CIR_IDLE && src_evt.pen_dav && !shared_q[`CIR_SHR_PEN_FIRST]
    && !(src_evt.out_thresh && shared_q[`CIR_SHR_OOT_FIRST])
    |=> !first_interrupt_output
  ) else $error("disabled pen event drove first output");

  insert_second_a: assert property ( // R1
    st_q[1] == CIR_IDLE && src_evt.hs_insert && en2_q[`CIR_EN2_INSERT]
    |=> second_interrupt_output ##1 second_interrupt_output
  ) else $error("insertion event missed on second output");

  oot_second_a: assert property ( // R12
    st_q[1] == CIR_IDLE && src_evt.out_thresh && shared_q[`CIR_SHR_OOT_SECOND]
    |=> second_interrupt_output
  ) else $error("threshold event missed on second output");

  idle_quiet_a: assert property ( // R18
    st_q[1] == CIR_IDLE && !trig[1] |=> !second_interrupt_output
  ) else $error("second output rose without an enabled event");

  pen_status_a: assert property ( // R13
    rd_req && req_idx == `CIR_IDX_SHARED
    |=> hrdata[`CIR_SHR_PEN_DOWN] == $past(touch_st.pen_down)
  ) else $error("pen status bit wrong on read");

  flag_sticky_a: assert property ( // R17
    src_evt.hs_insert |=> flags_q[8]
  ) else $error("event flag not set");

  // Each enabled second-output source starts a pulse from idle
  button_second_a: assert property ( // R2
    st_q[1] == CIR_IDLE && src_evt.button && en2_q[`CIR_EN2_BUTTON]
    |=> second_interrupt_output
  ) else $error("button event missed on second output");

  compress_second_a: assert property ( // R3
    st_q[1] == CIR_IDLE && src_evt.compress && en2_q[`CIR_EN2_COMPRESS]
    |=> second_interrupt_output
  ) else $error("compressor event missed on second output");

  noise_second_a: assert property ( // R4
    st_q[1] == CIR_IDLE && src_evt.gain_noise && en2_q[`CIR_EN2_GAIN_NOISE]
    |=> second_interrupt_output
  ) else $error("gain noise event missed on second output");

  short_second_a: assert property ( // R5
    st_q[1] == CIR_IDLE && src_evt.short_circ && en2_q[`CIR_EN2_SHORT]
    |=> second_interrupt_output
  ) else $error("short circuit event missed on second output");

  engine_second_a: assert property ( // R6
    st_q[1] == CIR_IDLE && src_evt.engine && en2_q[`CIR_EN2_ENGINE]
    |=> second_interrupt_output
  ) else $error("engine event missed on second output");

  dc_second_a: assert property ( // R7
    st_q[1] == CIR_IDLE && src_evt.dc_ready && en2_q[`CIR_EN2_DC_READY]
    |=> second_interrupt_output
  ) else $error("measurement ready event missed on second output");

  // Live converter levels must reach the read data of the shared word
  status_bits_a: assert property ( // R14 R15
    rd_req && req_idx == `CIR_IDX_SHARED
    |=> hrdata[`CIR_SHR_DATA_AVAIL] == $past(touch_st.data_avail)
    && hrdata[`CIR_SHR_OUT_RANGE] == $past(touch_st.out_range)
  ) else $error("converter status bits wrong on read");

endmodule : cir_top

// [hdl/cir_irq_map.svh]
// Register indices, field positions, reset values and timing figures
`ifndef CIR_IRQ_MAP_SVH
`define CIR_IRQ_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CIR_IDX_EN2 8'h31
`define CIR_IDX_SHARED 8'h32
`define CIR_IDX_FLAGS 8'h33
`define CIR_IDX_IRQ_STAT 8'h34
`define CIR_IDX_IRQ_MASK 8'h35

// ==========================================================
// Second-output source enable fields and the repeat mode bit
`define CIR_EN2_INSERT 7
`define CIR_EN2_BUTTON 6
`define CIR_EN2_COMPRESS 5
`define CIR_EN2_GAIN_NOISE 4
`define CIR_EN2_SHORT 3
`define CIR_EN2_ENGINE 2
`define CIR_EN2_DC_READY 1
`define CIR_EN2_REPEAT 0

// ==========================================================
// Shared register fields
`define CIR_SHR_OOT_FIRST 7
`define CIR_SHR_PEN_FIRST 6
`define CIR_SHR_OOT_SECOND 5
`define CIR_SHR_PEN_DOWN 3
`define CIR_SHR_DATA_AVAIL 2
`define CIR_SHR_OUT_RANGE 1
`define CIR_SHR_RW_MASK 8'he0

// ==========================================================
// Reset values
`define CIR_RST_EN2 8'h00
`define CIR_RST_SHARED 8'h00
`define CIR_RST_IRQ_MASK 2'h0

// ==========================================================
// Timing: milliseconds and clock rate in kHz
`define CIR_PULSE_MS 2
`define CIR_PERIOD_MS 4
`define CIR_CLK_KHZ 100000

`endif

// [hdl/cir_pkg.sv]
// Types shared by the interrupt routing block and its bench
package cir_pkg;

  // ==========================================================
  // Event pulses from the codec and touch logic
  typedef struct packed {
    logic hs_insert;
    logic button;
    logic compress;
    logic gain_noise;
    logic short_circ;
    logic engine;
    logic dc_ready;
    logic pen_dav;
    logic out_thresh;
  } cir_src_t;

  // Live touch and converter status levels
  typedef struct packed {
    logic pen_down;
    logic data_avail;
    logic out_range;
  } cir_touch_t;

  // Pulse sequencer states
  typedef enum logic [1:0] {
    CIR_IDLE,
    CIR_HIGH,
    CIR_LOW
  } cir_pulse_st_t;

endpackage : cir_pkg

// [test/cir_host_model.sv]
// Host-side model that watches both interrupt pins
module cir_host_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Interrupt pins from the device
  input wire logic pin_first,
  input wire logic pin_second,
  // Running tallies for the bench
  output int rise_first,
  output int rise_second,
  output int high_first,
  output int high_second
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_first_q;
  logic prev_second_q;
  // ==========
  // Pulse counting: a host only sees edges and widths, so it keeps totals of both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_first_q <= 1'b0;
      prev_second_q <= 1'b0;
      rise_first <= 0;
      rise_second <= 0;
      high_first <= 0;
      high_second <= 0;
    end else begin
      prev_first_q <= pin_first;
      prev_second_q <= pin_second;
      if (pin_first && !prev_first_q) rise_first <= rise_first + 1;
      if (pin_second && !prev_second_q) rise_second <= rise_second + 1;
      if (pin_first) high_first <= high_first + 1;
      if (pin_second) high_second <= high_second + 1;
    end
  end
endmodule : cir_host_model

// [test/tb_cir_top.sv]
// Self-checking bench for the interrupt routing block
`include "cir_irq_map.svh"
module tb_cir_top
  import cir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 20;
  localparam int PERIOD = 40;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, pin1, pin2;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cir_src_t src_evt;
  cir_touch_t touch_st;
  int rise1, rise2, high1, high2, num_errors, cmp_count, cyc;

  // ==========
  // Device and host
  cir_top #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .src_evt(src_evt), .touch_st(touch_st),
    .first_interrupt_output(pin1), .second_interrupt_output(pin2), .irq(irq));
  cir_host_model host (.hclk(hclk), .hresetn(hresetn), .pin_first(pin1), .pin_second(pin2),
    .rise_first(rise1), .rise_second(rise2), .high_first(high1), .high_second(high2));

  // ==========
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Single AHB-Lite transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
    #1;
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, idx, v, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0, rd);
  endtask : rd_reg

  // One-cycle event, returns once the pin update has landed
  task automatic fire(input logic [8:0] e);
    @(posedge hclk);
    src_evt <= cir_src_t'(e);
    @(posedge hclk);
    src_evt <= '0;
    #1;
  endtask : fire

  // Ends a sequence's aftermath: drain flags, clear status
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    rd_reg(`CIR_IDX_FLAGS);
    wr_reg(`CIR_IDX_IRQ_STAT, 32'h3);
  endtask : settle

  // ==========
  // Scenarios
  task automatic t_regs();
    rd_reg(`CIR_IDX_EN2);
    check(rd, 32'h0);
    rd_reg(`CIR_IDX_SHARED);
    check(rd, 32'h0);
    rd_reg(`CIR_IDX_IRQ_MASK);
    check({rd[31:1], hresp}, 32'h0);
    wr_reg(`CIR_IDX_EN2, 32'hffff_ffa5);
    rd_reg(`CIR_IDX_EN2);
    check(rd, 32'ha5);
    wr_reg(8'h3f, 32'hff);
    rd_reg(8'h3f);
    check(rd, 32'h0);
  endtask : t_regs

  task automatic t_status();
    wr_reg(`CIR_IDX_SHARED, 32'he0);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      touch_st <= cir_touch_t'(3'(i));
      rd_reg(`CIR_IDX_SHARED);
      check(rd, 32'he0 | (32'(i) << 1));
    end
    @(posedge hclk);
    touch_st <= '0;
    wr_reg(`CIR_IDX_SHARED, 32'h0);
  endtask : t_status

  task automatic t_second_src();
    int h0, r0;
    logic [8:0] e;
    for (int b = 7; b >= 1; b--) begin
      e = 9'h1 << (b + 1);
      wr_reg(`CIR_IDX_EN2, 32'h0);
      fire(e);
      check(pin2, 1'b0);
      rd_reg(`CIR_IDX_FLAGS);
      check(rd, {23'h0, e});
      rd_reg(`CIR_IDX_FLAGS);
      check(rd, 32'h0);
      wr_reg(`CIR_IDX_EN2, 32'h1 << b);
      h0 = high2;
      r0 = rise2;
      fire(e);
      check(pin2, 1'b1);
      repeat (PULSE + 5) @(posedge hclk);
      check(32'(high2 - h0), PULSE);
      check(32'(rise2 - r0), 32'h1);
      settle(0);
    end
  endtask : t_second_src

  task automatic t_shared_src();
    logic [7:0] shv [5] = '{8'h40, 8'h00, 8'h80, 8'h20, 8'h00};
    logic [8:0] ev [5] = '{9'h002, 9'h002, 9'h001, 9'h001, 9'h001};
    logic [1:0] ex [5] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
    int h1, h2;
    for (int i = 0; i < 5; i++) begin
      wr_reg(`CIR_IDX_SHARED, {24'h0, shv[i]});
      wr_reg(`CIR_IDX_EN2, 32'h0);
      h1 = high1;
      h2 = high2;
      fire(ev[i]);
      check({pin1, pin2}, ex[i]);
      settle(PULSE + 5);
      check(32'(high1 - h1), ex[i][1] ? PULSE : 0);
      check(32'(high2 - h2), ex[i][0] ? PULSE : 0);
    end
  endtask : t_shared_src

  // A second event inside a running pulse must not stretch or restart it
  task automatic t_restart();
    int h0, r0;
    wr_reg(`CIR_IDX_EN2, 32'h80);
    h0 = high2;
    r0 = rise2;
    fire(9'h100);
    repeat (5) @(posedge hclk);
    fire(9'h100);
    repeat (PULSE + 10) @(posedge hclk);
    check(32'(high2 - h0), PULSE);
    check(32'(rise2 - r0), 32'h1);
    settle(0);
  endtask : t_restart

  task automatic t_repeat();
    int r0;
    wr_reg(`CIR_IDX_EN2, 32'h81);
    r0 = rise2;
    fire(9'h100);
    repeat (2 * PERIOD + 5) @(posedge hclk);
    check(32'(rise2 - r0), 32'h3);
    rd_reg(`CIR_IDX_FLAGS);
    repeat (PERIOD) @(posedge hclk);
    check(32'(rise2 - r0), 32'h4);
    rd_reg(`CIR_IDX_SHARED);
    repeat (2 * PERIOD + 5) @(posedge hclk);
    check(32'(rise2 - r0), 32'h4);
    check(pin2, 1'b0);
    wr_reg(`CIR_IDX_EN2, 32'h0);
    settle(0);
  endtask : t_repeat

  task automatic t_irq();
    wr_reg(`CIR_IDX_EN2, 32'h80);
    fire(9'h100);
    rd_reg(`CIR_IDX_IRQ_STAT);
    check({rd[31:1], irq}, 32'h2);
    wr_reg(`CIR_IDX_IRQ_MASK, 32'h2);
    check(irq, 1'b1);
    wr_reg(`CIR_IDX_IRQ_STAT, 32'h2);
    check(irq, 1'b0);
    rd_reg(`CIR_IDX_IRQ_STAT);
    check(rd, 32'h0);
    wr_reg(`CIR_IDX_IRQ_MASK, 32'h0);
    settle(PULSE);
  endtask : t_irq

  // ==========
  // Verdict and run control
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    src_evt = '0;
    touch_st = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_status();
    t_second_src();
    t_shared_src();
    t_restart();
    t_repeat();
    t_irq();
    tally_and_finish();
  end
endmodule : tb_cir_top
